// ### rtl/csc_pkg.sv
// Shared constants for the converter status and control register bank
package csc_pkg;

	// ---------------------------------------------------------------
	// Register offsets (serial register pointer values)
	// ---------------------------------------------------------------
	localparam logic [7:0] CSC_OFS_SRC  = 8'h10;
	localparam logic [7:0] CSC_OFS_MASK = 8'h11;
	localparam logic [7:0] CSC_OFS_CTL1 = 8'h12;
	localparam logic [7:0] CSC_OFS_VREF = 8'h13;

	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int CSC_BIT_POK   = 4;
	localparam int CSC_BIT_OVP   = 3;
	localparam int CSC_BIT_SHORT = 2;
	localparam int CSC_BIT_THS   = 1;
	localparam int CSC_BIT_OCP   = 0;
	localparam int CSC_COMP_LSB  = 5;
	localparam int CSC_RATE_LSB  = 3;
	localparam int CSC_CURRENT_LIMIT_SELECT_LSB  = 0;

	// ---------------------------------------------------------------
	// Reset values
	// ---------------------------------------------------------------
	localparam logic [3:0] CSC_RST_FLAGS = 4'h0;
	localparam logic [7:0] CSC_RST_MASK  = 8'h0f;
	localparam logic [2:0] CSC_RST_COMP  = 3'h2;
	localparam logic [1:0] CSC_RST_RATE  = 2'h2;
	localparam logic [2:0] CSC_RST_CURRENT_LIMIT_SELECT  = 3'h0;
	localparam logic [7:0] CSC_RST_VREF  = 8'h44;

	// ---------------------------------------------------------------
	// Reference code clamp limits
	// ---------------------------------------------------------------
	localparam logic [7:0] CSC_VREF_LO = 8'h3d;
	localparam logic [7:0] CSC_VREF_HI = 8'hcc;

	// ---------------------------------------------------------------
	// Serial engine
	// ---------------------------------------------------------------
	localparam logic [3:0] CSC_BITS_BYTE = 4'h8;
	localparam logic [6:0] CSC_DEV_ADDR  = 7'h5a;

	typedef enum logic [3:0] {
		ST_IDLE   = 4'b0000,
		ST_ADDR   = 4'b0001,
		ST_ACK_AD = 4'b0010,
		ST_PTR    = 4'b0011,
		ST_ACK_PT = 4'b0100,
		ST_WDATA  = 4'b0101,
		ST_ACK_WR = 4'b0110,
		ST_RDATA  = 4'b0111,
		ST_ACK_RD = 4'b1000
	} csc_state_type;

endpackage

// ### rtl/csc_sync.sv
// Three-stage input synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none

module csc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         reset,
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] filt_q
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;

	// ---------------------------------------------------------------
	// Per-bit chain; a change counts once stages two and three agree
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// Chain keeps sampling through reset, so the output already shows
			// the settled pin level on release and no false edge follows it
			always_ff @(posedge clk) begin
				s1_q[i] <= async_in[i];
				s2_q[i] <= s1_q[i];
				s3_q[i] <= s2_q[i];
				if (reset || (s2_q[i] == s3_q[i])) begin
					filt_q[i] <= s3_q[i];
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ### rtl/csc_regs.sv
// Converter status and control registers behind a serial two-wire slave
//
// Functional notes
// [RQ1] Source bits 7..5 read zero, unwritable
// [RQ2] Source bit 4 shows live power-good
// [RQ3] Source bit 3 latches overvoltage
// [RQ4] Source bit 2 latches hard short
// [RQ5] Source bit 1 latches thermal shutdown
// [RQ6] Source bit 0 latches overcurrent
// [RQ7] Source register read-only, resets zero
// [RQ8] Mask bit 4 gates power-good, resets 0
// [RQ9] Mask bit 3 gates overvoltage, resets 1
// [RQ10] Mask bit 2 gates hard short, resets 1
// [RQ11] Mask bit 1 gates thermal, resets 1
// [RQ12] Mask bit 0 gates overcurrent, resets 1
// [RQ13] Control bits 7..5 compensation, reset 010
// [RQ14] Control bits 4..3 switching rate, reset 10
// [RQ15] Control bits 2..0 current limit, reset 000
// [RQ16] Reference codes up to 0x3C clamp low
// [RQ17] Codes 0x3D..0xCC map linearly
// [RQ18] Codes above 0xCC clamp; reset 0x44
// [RQ19] Shutdown returns all registers to reset
// [RQ20] Pointer write, repeated start, read 8 bits
// [RQ21] Write data lands on acknowledge rising clock
// [RQ22] Interrupt while any unmasked source set
// [RQ23] Writes to source register are ignored
`timescale 1ns/1ps
`default_nettype none

module csc_regs
	import csc_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = CSC_DEV_ADDR
) (
	input  wire logic       clk,
	input  wire logic       reset,
	input  wire logic       shutdown,
	input  wire logic       scl_in,
	input  wire logic       sda_in,
	output logic            sda_out,
	output logic            sda_oe,
	input  wire logic       power_good_in,
	input  wire logic       overvoltage_in,
	input  wire logic       hard_short_in,
	input  wire logic       thermal_in,
	input  wire logic       overcurrent_in,
	output logic            irq_q,
	output logic [2:0]      comp_select_q,
	output logic [1:0]      switching_rate_select_q,
	output logic [2:0]      current_limit_select_q,
	output logic [7:0]      ref_dac_q
);

	// ---------------------------------------------------------------
	// Synchronised pins
	// ---------------------------------------------------------------
	logic [7:0] pin_s;
	logic       shut_s;
	logic       pok_s;
	logic [3:0] fault_s;
	logic       scl_s;
	logic       sda_s;

	csc_sync #(.W(8)) u_sync (
		.clk      (clk),
		.reset    (reset),
		.async_in ({shutdown, power_good_in, overvoltage_in, hard_short_in,
		            thermal_in, overcurrent_in, scl_in, sda_in}),
		.filt_q   (pin_s)
	);

	assign shut_s  = pin_s[7];
	assign pok_s   = pin_s[6];
	assign fault_s = pin_s[5:2];
	assign scl_s   = pin_s[1];
	assign sda_s   = pin_s[0];

	// Shutdown clears exactly like reset, so nothing survives a power cycle
	logic clr;
	assign clr = reset | shut_s; // [RQ19]

	// ---------------------------------------------------------------
	// Bus edge and condition detection
	// ---------------------------------------------------------------
	logic scl_prev_q;
	logic sda_prev_q;
	logic scl_rise;
	logic scl_fall;
	logic bus_start;
	logic bus_stop;

	assign scl_rise  = scl_s & ~scl_prev_q;
	assign scl_fall  = ~scl_s & scl_prev_q;
	assign bus_start = scl_s & scl_prev_q & sda_prev_q & ~sda_s;
	assign bus_stop  = scl_s & scl_prev_q & ~sda_prev_q & sda_s;

	always_ff @(posedge clk) begin
		if (clr) begin
			scl_prev_q <= 1'b1;
			sda_prev_q <= 1'b1;
		end else begin
			scl_prev_q <= scl_s;
			sda_prev_q <= sda_s;
		end
	end

	// ---------------------------------------------------------------
	// Register storage
	// ---------------------------------------------------------------
	csc_state_type state_q;
	logic [7:0]    shreg_q;
	logic [7:0]    tx_q;
	logic [3:0]    cnt_q;
	logic [7:0]    ptr_q;
	logic          rw_q;
	logic [3:0]    flags_q;
	logic [7:0]    mask_q;
	logic [7:0]    vref_q;

	logic       wr_stb;
	logic [7:0] src_value;
	logic [7:0] ctl1_value;
	logic [7:0] rd_data;
	logic       byte_done;
	logic       addr_hit;

	assign byte_done = (cnt_q == CSC_BITS_BYTE);
	assign addr_hit  = (shreg_q[7:1] == DEV_ADDR);
	assign wr_stb    = (state_q == ST_ACK_WR) & scl_rise; // [RQ21]

	// Upper three bits are wired to zero; no storage exists for them
	assign src_value  = {3'h0, pok_s, flags_q}; // [RQ1] [RQ2]
	assign ctl1_value = {comp_select_q, switching_rate_select_q,
	                     current_limit_select_q};

	// Unmapped pointers read as zero
	assign rd_data = (ptr_q == CSC_OFS_SRC)  ? src_value :
	                 (ptr_q == CSC_OFS_MASK) ? mask_q :
	                 (ptr_q == CSC_OFS_CTL1) ? ctl1_value :
	                 (ptr_q == CSC_OFS_VREF) ? vref_q : 8'h00; // [RQ20]

	// Fault flags: latch on the event, clear only on reset or shutdown
	always_ff @(posedge clk) begin
		if (clr) begin
			flags_q <= CSC_RST_FLAGS; // [RQ7]
		end else begin
			flags_q <= flags_q | fault_s; // [RQ3] [RQ4] [RQ5] [RQ6] [RQ23]
		end
	end

	always_ff @(posedge clk) begin
		if (clr) begin
			mask_q                  <= CSC_RST_MASK; // [RQ8] [RQ9] [RQ10] [RQ11] [RQ12]
			comp_select_q           <= CSC_RST_COMP; // [RQ13]
			switching_rate_select_q <= CSC_RST_RATE; // [RQ14]
			current_limit_select_q  <= CSC_RST_CURRENT_LIMIT_SELECT; // [RQ15]
			vref_q                  <= CSC_RST_VREF; // [RQ18]
		end else if (wr_stb) begin
			if (ptr_q == CSC_OFS_MASK) begin
				mask_q <= shreg_q;
			end
			if (ptr_q == CSC_OFS_CTL1) begin
				comp_select_q           <= shreg_q[CSC_COMP_LSB +: 3]; // [RQ13]
				switching_rate_select_q <= shreg_q[CSC_RATE_LSB +: 2]; // [RQ14]
				current_limit_select_q  <= shreg_q[CSC_CURRENT_LIMIT_SELECT_LSB +: 3]; // [RQ15]
			end
			if (ptr_q == CSC_OFS_VREF) begin
				vref_q <= shreg_q;
			end
		end
	end

	// ---------------------------------------------------------------
	// Reference clamp and interrupt
	// ---------------------------------------------------------------
	// Register reads back the raw code; only the DAC sees the clamped one
	logic [7:0] vref_eff;
	logic [4:0] irq_src;
	assign vref_eff = (vref_q < CSC_VREF_LO) ? CSC_VREF_LO :
	                  (vref_q > CSC_VREF_HI) ? CSC_VREF_HI : vref_q; // [RQ16] [RQ17] [RQ18]
	assign irq_src  = src_value[4:0] & ~mask_q[4:0]; // [RQ8] [RQ9] [RQ10] [RQ11] [RQ12]

	always_ff @(posedge clk) begin
		if (clr) begin
			ref_dac_q <= CSC_RST_VREF;
			irq_q     <= 1'b0;
		end else begin
			ref_dac_q <= vref_eff;
			irq_q     <= |irq_src; // [RQ22]
		end
	end

	// ---------------------------------------------------------------
	// Serial slave engine
	// ---------------------------------------------------------------
	// Open-drain: the pin is only ever pulled low
	always_ff @(posedge clk) begin
		sda_out <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (clr) begin
			state_q <= ST_IDLE;
			shreg_q <= 8'h00;
			tx_q    <= 8'h00;
			cnt_q   <= 4'h0;
			ptr_q   <= 8'h00;
			rw_q    <= 1'b0;
			sda_oe  <= 1'b0;
		end else if (bus_start) begin
			state_q <= ST_ADDR;
			cnt_q   <= 4'h0;
			sda_oe  <= 1'b0;
		end else if (bus_stop) begin
			state_q <= ST_IDLE;
			sda_oe  <= 1'b0;
		end else begin
			unique case (state_q)
				ST_IDLE: begin
				end
				ST_ADDR, ST_PTR, ST_WDATA: begin
					if (scl_rise) begin
						shreg_q <= {shreg_q[6:0], sda_s};
						cnt_q   <= cnt_q + 4'h1;
					end else if (scl_fall && byte_done) begin
						cnt_q <= 4'h0;
						if (state_q == ST_ADDR) begin
							state_q <= addr_hit ? ST_ACK_AD : ST_IDLE;
							sda_oe  <= addr_hit;
							rw_q    <= shreg_q[0];
						end else if (state_q == ST_PTR) begin
							ptr_q   <= shreg_q; // [RQ20]
							state_q <= ST_ACK_PT;
							sda_oe  <= 1'b1;
						end else begin
							state_q <= ST_ACK_WR;
							sda_oe  <= 1'b1;
						end
					end
				end
				ST_ACK_AD: begin
					if (scl_fall) begin
						if (rw_q) begin
							tx_q    <= {rd_data[6:0], 1'b0}; // [RQ20]
							sda_oe  <= ~rd_data[7];
							cnt_q   <= 4'h1;
							state_q <= ST_RDATA;
						end else begin
							sda_oe  <= 1'b0;
							state_q <= ST_PTR;
						end
					end
				end
				ST_ACK_PT: begin
					if (scl_fall) begin
						sda_oe  <= 1'b0;
						state_q <= ST_WDATA;
					end
				end
				ST_ACK_WR: begin
					if (scl_rise) begin
						ptr_q <= ptr_q + 8'h01;
					end else if (scl_fall) begin
						sda_oe  <= 1'b0;
						state_q <= ST_WDATA;
					end
				end
				ST_RDATA: begin
					if (scl_fall) begin
						if (byte_done) begin
							sda_oe  <= 1'b0;
							ptr_q   <= ptr_q + 8'h01;
							state_q <= ST_ACK_RD;
						end else begin
							sda_oe <= ~tx_q[7];
							tx_q   <= {tx_q[6:0], 1'b0};
							cnt_q  <= cnt_q + 4'h1;
						end
					end
				end
				ST_ACK_RD: begin
					// A not-acknowledge ends the read; the slave then idles until the next start
					if (scl_rise && sda_s) begin
						state_q <= ST_IDLE;
					end else if (scl_fall) begin
						tx_q    <= {rd_data[6:0], 1'b0};
						sda_oe  <= ~rd_data[7];
						cnt_q   <= 4'h1;
						state_q <= ST_RDATA;
					end
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (clr);

	a_unused_bit_read_zero: assert property (src_value[7:5] == 3'h0) // [RQ1]
		else $error("Reserved source bits not zero");

	a_pok_live_value: assert property (src_value[CSC_BIT_POK] == pok_s) // [RQ2]
		else $error("Power-good bit does not follow input");

	a_ovp_latch_hold: assert property (fault_s[3] |=> flags_q[CSC_BIT_OVP] [*2]) // [RQ3]
		else $error("Overvoltage flag not latched");

	a_short_latch_hold: assert property (flags_q[CSC_BIT_SHORT] |=> flags_q[CSC_BIT_SHORT]) // [RQ4]
		else $error("Hard short flag dropped");

	a_ths_latch_set: assert property ($rose(fault_s[1]) |=> $rose(flags_q[CSC_BIT_THS])
		|| $past(flags_q[CSC_BIT_THS])) // [RQ5]
		else $error("Thermal flag not set");

	a_ocp_no_spurious: assert property (!fault_s[0] && !flags_q[CSC_BIT_OCP]
		|=> !flags_q[CSC_BIT_OCP]) // [RQ6]
		else $error("Overcurrent flag set without event");

	a_src_write_ignored: assert property (wr_stb && ptr_q == CSC_OFS_SRC && fault_s == 4'h0
		|=> $stable(flags_q)) // [RQ23]
		else $error("Source register altered by write");

	a_reset_defaults: assert property ($past(clr) |-> mask_q == CSC_RST_MASK
		&& vref_q == CSC_RST_VREF && comp_select_q == CSC_RST_COMP
		&& switching_rate_select_q == CSC_RST_RATE && flags_q == CSC_RST_FLAGS
		&& current_limit_select_q == CSC_RST_CURRENT_LIMIT_SELECT) // [RQ19]
		else $error("Register not at reset value");

	a_ctl_write_ack: assert property (wr_stb && ptr_q == CSC_OFS_CTL1
		|=> ctl1_value == $past(shreg_q)) // [RQ21]
		else $error("Control write not loaded on ack edge");

	a_ref_clamp_range: assert property (##1 ref_dac_q >= CSC_VREF_LO
		&& ref_dac_q <= CSC_VREF_HI) // [RQ16]
		else $error("Reference code outside clamp range");

	a_irq_follows: assert property ((irq_src != 5'h0) |=> irq_q ##0 (irq_src != 5'h0
		|| $past(irq_src) != 5'h0)) // [RQ22]
		else $error("Interrupt not raised for unmasked source");

	a_irq_quiet: assert property ((irq_src == 5'h0) |=> !irq_q) // [RQ22]
		else $error("Interrupt raised while all masked");

	c_ctl_write:  cover property (wr_stb && ptr_q == CSC_OFS_CTL1);
	c_read_byte:  cover property (state_q == ST_RDATA && byte_done && scl_fall);
	c_irq_rise:   cover property ($rose(irq_q));
	c_vref_clamp: cover property (wr_stb && ptr_q == CSC_OFS_VREF && shreg_q > CSC_VREF_HI);

endmodule

`default_nettype wire

// ### bench/csc_host.sv
// Two-wire bus host model that reads and writes the register bank
`timescale 1ns/1ps
`default_nettype none

module csc_host #(
	parameter logic [6:0] ADDR = 7'h5a
) (
	output logic      scl,
	output logic      sda_low,
	input  wire logic sda
);
	// Each 200 ns bit is SCL low for 3Q and high for Q: the slave answers about
	// five clocks after a falling edge, so the long low phase keeps its SDA
	// change clear of the next rising edge on both sides of the filter
	localparam time Q = 50;

	initial begin
		scl = 1'b1;
		sda_low = 1'b0;
	end

	// ----
	// Bus phases
	// ----
	task automatic start_c();
		sda_low = 1'b0;
		// Let the slave drop its acknowledge before SCL rises
		#(3 * Q) scl = 1'b1;
		#Q sda_low = 1'b1;
		#Q scl = 1'b0;
	endtask

	task automatic stop_c();
		#Q sda_low = 1'b1;
		#(2 * Q) scl = 1'b1;
		#Q sda_low = 1'b0;
		#Q;
	endtask

	// Eight bits MSB first plus the acknowledge slot; a 1 releases SDA
	task automatic byte9(input logic [8:0] o, output logic [8:0] i);
		for (int k = 8; k >= 0; k--) begin
			#Q sda_low = !o[k];
			#(2 * Q) scl = 1'b1;
			// Sampled at the end of the high phase, past the slave's drive delay
			#Q i[k] = sda;
			scl = 1'b0;
		end
	endtask

	// ----
	// Register access
	// ----
	task automatic wr(input logic [7:0] p, input logic [7:0] d, output logic ok);
		logic [8:0] a, b, c;
		start_c();
		byte9({ADDR, 1'b0, 1'b1}, a);
		byte9({p, 1'b1}, b);
		byte9({d, 1'b1}, c);
		stop_c();
		ok = (a[0] | b[0] | c[0]) === 1'b0;
	endtask

	// Pointer write, repeated start, one byte ended by a not-acknowledge
	task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic ok);
		logic [8:0] a, b, c, e;
		start_c();
		byte9({ADDR, 1'b0, 1'b1}, a);
		byte9({p, 1'b1}, b);
		start_c();
		byte9({ADDR, 1'b1, 1'b1}, c);
		byte9(9'h1ff, e);
		stop_c();
		d = e[8:1];
		ok = (a[0] | b[0] | c[0]) === 1'b0;
	endtask
endmodule

`default_nettype wire

// ### bench/testbench.sv
// Self-checking bench for the converter status and control registers
`timescale 1ns/1ps
`default_nettype none

module testbench
	import csc_pkg::*;
;
	typedef struct packed {
		logic [7:0] ptr, wd, rd, ctl, vr;
	} csc_row_type;

	logic       clk, reset, shutdown, pg, irq;
	logic       scl, sda_low, sda_out, sda_oe;
	wire        sda;
	logic [3:0] flt, acc;
	logic [2:0] comp, current_limit_select;
	logic [1:0] rate;
	logic [7:0] ref_dac;
	int         n_fail, num_checks, cyc;

	// Wired-AND bus with pull-up: low while either side pulls
	assign sda = !(sda_low || (sda_oe && !sda_out));

	csc_regs dut (.clk(clk), .reset(reset), .shutdown(shutdown), .scl_in(scl),
		.sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe), .power_good_in(pg),
		.overvoltage_in(flt[3]), .hard_short_in(flt[2]), .thermal_in(flt[1]),
		.overcurrent_in(flt[0]), .irq_q(irq), .comp_select_q(comp),
		.switching_rate_select_q(rate), .current_limit_select_q(current_limit_select),
		.ref_dac_q(ref_dac));

	csc_host host (.scl(scl), .sda_low(sda_low), .sda(sda));

	csc_row_type rows [8] = '{
		'{8'h12, 8'hab, 8'hab, 8'hab, 8'h44},
		'{8'h13, 8'h3c, 8'h3c, 8'hab, 8'h3d},
		'{8'h13, 8'hcd, 8'hcd, 8'hab, 8'hcc},
		'{8'h13, 8'h80, 8'h80, 8'hab, 8'h80},
		'{8'h10, 8'hff, 8'h00, 8'hab, 8'h80},
		'{8'h20, 8'h55, 8'h00, 8'hab, 8'h80},
		'{8'h12, 8'h07, 8'h07, 8'h07, 8'h80},
		'{8'h11, 8'he0, 8'he0, 8'h07, 8'h80}
	};

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// ----
	// Checking and bus helpers
	// ----
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		num_checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] p, input logic [7:0] d);
		logic ok;
		host.wr(p, d, ok);
		chk("write ack", 8'h01, {7'h00, ok});
	endtask

	task automatic rd(input logic [7:0] p, input logic [7:0] e, input string nm);
		logic       ok;
		logic [7:0] d;
		host.rd(p, d, ok);
		chk("read ack", 8'h01, {7'h00, ok});
		chk(nm, e, d);
	endtask

	task automatic rst_chk(input logic p);
		rd(CSC_OFS_SRC, {3'h0, p, CSC_RST_FLAGS}, "source");
		rd(CSC_OFS_MASK, CSC_RST_MASK, "mask");
		rd(CSC_OFS_CTL1, 8'h50, "control");
		rd(CSC_OFS_VREF, CSC_RST_VREF, "reference");
		chk("ctl out", 8'h50, {comp, rate, current_limit_select});
		chk("ref out", CSC_RST_VREF, ref_dac);
		chk("irq", {7'h00, p}, {7'h00, irq});
	endtask

	task automatic give_verdict();
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Whole run is near 13000 cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 40000) begin
			n_fail++;
			give_verdict();
		end
	end

	// ----
	// Main sequence
	// ----
	initial begin
		reset = 1'b1;
		shutdown = 1'b0;
		pg = 1'b0;
		flt = 4'h0;
		acc = 4'h0;
		repeat (20) @(negedge clk);
		reset = 1'b0;
		repeat (10) @(negedge clk);
		rst_chk(1'b0);
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].ptr, rows[i].wd);
			rd(rows[i].ptr, rows[i].rd, "readback");
			chk("ctl out", rows[i].ctl, {comp, rate, current_limit_select});
			chk("ref out", rows[i].vr, ref_dac);
		end
		chk("irq idle", 8'h00, {7'h00, irq});
		$display("test rows done");
		pg = 1'b1;
		repeat (10) @(negedge clk);
		chk("irq pok", 8'h01, {7'h00, irq});
		rd(CSC_OFS_SRC, 8'h10, "source pok");
		wr(CSC_OFS_MASK, 8'h10);
		chk("irq pok masked", 8'h00, {7'h00, irq});
		$display("test pok done");
		for (int k = 0; k < 4; k++) begin
			wr(CSC_OFS_MASK, 8'h1f);
			flt[k] = 1'b1;
			repeat (4) @(negedge clk);
			flt = 4'h0;
			acc[k] = 1'b1;
			repeat (10) @(negedge clk);
			chk("irq masked", 8'h00, {7'h00, irq});
			rd(CSC_OFS_SRC, {4'h1, acc}, "source flag");
			wr(CSC_OFS_MASK, 8'h1f & ~(8'h01 << k));
			chk("irq unmasked", 8'h01, {7'h00, irq});
		end
		pg = 1'b0;
		repeat (10) @(negedge clk);
		rd(CSC_OFS_SRC, 8'h0f, "flags held");
		$display("test faults done");
		pg = 1'b1;
		shutdown = 1'b1;
		repeat (10) @(negedge clk);
		shutdown = 1'b0;
		repeat (10) @(negedge clk);
		rst_chk(1'b1);
		$display("test shutdown done");
		wr(CSC_OFS_VREF, 8'h99);
		wr(CSC_OFS_MASK, 8'h1f);
		chk("irq before reset", 8'h00, {7'h00, irq});
		reset = 1'b1;
		repeat (20) @(negedge clk);
		reset = 1'b0;
		repeat (10) @(negedge clk);
		rst_chk(1'b1);
		$display("test mid-run reset done");
		give_verdict();
	end
endmodule

`default_nettype wire
